// ---- core/sps_regs.vh ----
// sps_regs.vh: constants for the stand-alone programming sequencer
// assumes: included by core/sps_sequencer.v, no other dependencies
`ifndef SPS_REGS_VH
`define SPS_REGS_VH

// ************************************************************
// AHB-Lite register map (byte addresses)
// ************************************************************
`define SPS_CTRL_ADDR      12'h000
`define SPS_STAT_ADDR      12'h004
`define SPS_SIZE_ADDR      12'h008
`define SPS_DATA_SIZE_ADDR 12'h00C
`define SPS_ADDR_MSB       11
`define SPS_ADDR_LSB       2

// ************************************************************
// control register fields
// ************************************************************
`define SPS_CTRL_START     0
`define SPS_CTRL_TWO_OPT   1

// ************************************************************
// status register fields
// ************************************************************
`define SPS_ST_BUSY        0
`define SPS_ST_OK          1
`define SPS_ST_FAULT       2
`define SPS_ST_VALID       3

// ************************************************************
// reset values and memory layout
// ************************************************************
`define SPS_SIZE_RST       16'h1000
`define SPS_DSIZE_RST      16'h0080
`define SPS_DATA_OFS       16'h0100
`define SPS_BLANK_BYTE     8'hFF
`define SPS_UNLOCK_OPT     8'hFF
`define SPS_PROTECT_MASK   8'hFE

// ************************************************************
// timing
// ************************************************************
`define SPS_CLK_HZ         20000000
`define SPS_FLASH_MS       250

`endif

// ---- core/sps_sequencer.v ----
// sps_sequencer.v: stand-alone control sequencer of a programming board
// assumes: one clock hclk at 20 MHz, async active-low reset hresetn,
// panel switches and jumpers are asynchronous pins, part buses are byte wide
// with one-cycle strobes and answers on the next cycle.
//
// Functional notes
// - OTP jumper marks part one-time programmable
// - EEPROM jumper restricts work to data space
// - RAM source, master, START reads reference
// - reference read also compares board memory
// - busy indicator lit during every operation, toggling every FLASH_CYC cycles
// - success leaves green indicator lit
// - failure leaves red fault indicator lit
// - read-protected part ends read, verify or blank check with all lit
// - board memory kept until next read
// - reference chip program bytes from zero
// - option byte at program size, high next
// - data bytes start at size plus 0x100
// - empty reference chip, target, verify: blank check
// - target, program, START programs the target
// - read protection applied at completion only
// - protect-inhibit jumper keeps option unprotectable
// - protected reference refused as source
// - target, verify, START compares target
// - further START programs new part
//
// Chosen here: the address map and the AHB-Lite register port.
`include "sps_regs.vh"
module sps_sequencer #(
	parameter AW         = 14,
	parameter FLASH_CYC  = (`SPS_CLK_HZ / 1000) * `SPS_FLASH_MS
) (
	// clock and reset
	input  wire          hclk,
	input  wire          hresetn,
	// ahb-lite slave
	input  wire          hsel,
	input  wire [31:0]   haddr,
	input  wire [1:0]    htrans,
	input  wire          hwrite,
	input  wire [2:0]    hsize,
	input  wire [31:0]   hwdata,
	input  wire          hready,
	output reg  [31:0]   hrdata,
	output wire          hreadyout,
	output wire          hresp,
	// front panel and jumpers
	input  wire          start_key_n,
	input  wire          source_master,
	input  wire          operation_select_switch,
	input  wire          ram_ref_jumper,
	input  wire          otp_jumper,
	input  wire          eeprom_jumper,
	input  wire          read_protect_jumper,
	input  wire          unlock_jumper,
	// indicators
	output wire          busy_indicator,
	output reg           fault_indicator,
	output reg           success_indicator,
	output reg           part_is_otp,
	// part access: target or reference mcu
	output reg           part_rd,
	output reg           part_wr,
	output reg           part_ref,
	output reg  [AW-1:0] part_addr,
	output reg           part_data_space,
	output reg  [7:0]    part_wdata,
	input  wire [7:0]    part_rdata,
	input  wire          part_locked,
	input  wire          part_lock_cmd_ok,
	output reg           part_lock,
	// reference memory chip
	output reg           refchip_rd,
	output reg  [15:0]   refchip_addr,
	input  wire [7:0]    refchip_rdata
);

	// ************************************************************
	// states and operations
	// ************************************************************
	localparam S_IDLE  = 3'd0;
	localparam S_REQ   = 3'd1;
	localparam S_WAIT  = 3'd2;
	localparam S_DATA  = 3'd3;
	localparam S_LOCK  = 3'd4;
	localparam S_DONE  = 3'd5;
	localparam OP_READ = 2'd0;
	localparam OP_PROG = 2'd1;
	localparam OP_VERI = 2'd2;
	localparam OP_BLNK = 2'd3;
	localparam PH_PROG = 2'd0;
	localparam PH_OPTL = 2'd1;
	localparam PH_OPTH = 2'd2;
	localparam PH_DATA = 2'd3;
	localparam [AW-1:0] AONE = {{(AW-1){1'b0}}, 1'b1};

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	reg [7:0] pin_s1_reg;
	reg [7:0] pin_s2_reg;
	reg       key_last_reg;
	wire [7:0] pins_raw = {unlock_jumper, read_protect_jumper, eeprom_jumper,
		otp_jumper, ram_ref_jumper, operation_select_switch, source_master,
		~start_key_n};

	// two flip-flops before any logic sees a pin
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_s1_reg   <= 8'h00;
			pin_s2_reg   <= 8'h00;
			key_last_reg <= 1'b0;
		end else begin
			pin_s1_reg   <= pins_raw;
			pin_s2_reg   <= pin_s1_reg;
			key_last_reg <= pin_s2_reg[0];
		end
	end

	// ************************************************************
	// state and board memory
	// ************************************************************
	reg [2:0]    state_reg;
	reg [1:0]    op_reg;
	reg [1:0]    phase_reg;
	reg [AW-1:0] idx_reg;
	reg [7:0]    cfg_reg;        // settings latched at START
	reg          err_reg;
	reg          prot_reg;
	reg          valid_reg;
	reg          busy_reg;
	reg          sw_start_reg;
	reg          two_opt_reg;
	reg [15:0]   size_reg;
	reg [15:0]   dsize_reg;
	reg [23:0]   flash_cnt_reg;
	reg          flash_reg;
	reg [7:0]    prog_mem [0:(1<<AW)-1];
	reg [7:0]    data_mem [0:255];
	reg [7:0]    opt_lo_reg;
	reg [7:0]    opt_hi_reg;
	reg [7:0]    ref_byte;
	reg [7:0]    want_byte;

	wire key_edge  = pin_s2_reg[0] & ~key_last_reg;
	wire go        = (key_edge | sw_start_reg) & ~busy_reg;
	wire c_master  = cfg_reg[1];
	wire c_prog    = cfg_reg[2];
	wire c_ram     = cfg_reg[3];
	wire c_eeprom  = cfg_reg[5];
	wire c_protect = cfg_reg[6];
	wire c_unlock  = cfg_reg[7];
	wire [AW-1:0] prog_last = size_reg[AW-1:0] - AONE;
	wire [AW-1:0] data_last = dsize_reg[AW-1:0] - AONE;
	wire [AW-1:0] phase_last = (phase_reg == PH_PROG) ? prog_last :
		(phase_reg == PH_DATA) ? data_last : {AW{1'b0}};

	// byte the source holds for the current phase and index
	always @* begin
		case (phase_reg)
			PH_PROG: ref_byte = prog_mem[idx_reg];
			PH_OPTL: ref_byte = opt_lo_reg;
			PH_OPTH: ref_byte = opt_hi_reg;
			default: ref_byte = data_mem[idx_reg[7:0]];
		endcase
		if (!c_ram)
			ref_byte = refchip_rdata;
		want_byte = ref_byte;
		if (op_reg == OP_BLNK)
			want_byte = `SPS_BLANK_BYTE;
		if (phase_reg == PH_OPTL && c_unlock && op_reg == OP_PROG)
			want_byte = `SPS_UNLOCK_OPT;
	end

	// next phase after the current one ends
	function [2:0] next_phase;
		input [1:0] ph;
		input       two;
		input       dsp;
		begin
			case (ph)
				PH_PROG: next_phase = {1'b0, PH_OPTL};
				PH_OPTL: next_phase = two ? {1'b0, PH_OPTH} : {1'b0, PH_DATA};
				PH_OPTH: next_phase = {1'b0, PH_DATA};
				default: next_phase = 3'b100;
			endcase
			if (dsp && ph != PH_DATA)
				next_phase = {1'b0, PH_DATA};
		end
	endfunction
	wire [AW-1:0] opt_addr = size_reg[AW-1:0] + {{(AW-1){1'b0}}, phase_reg[1]};
	wire [2:0] nph = next_phase(phase_reg, two_opt_reg, c_eeprom);
	wire       mis = (op_reg == OP_READ) ? (part_rdata != ref_byte) : (part_rdata != want_byte);
	// ************************************************************
	// sequencer
	// ************************************************************
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg         <= S_IDLE;
			op_reg            <= OP_READ;
			phase_reg         <= PH_PROG;
			idx_reg           <= {AW{1'b0}};
			cfg_reg           <= 8'h00;
			err_reg           <= 1'b0;
			prot_reg          <= 1'b0;
			valid_reg         <= 1'b0;
			busy_reg          <= 1'b0;
			fault_indicator   <= 1'b0;
			success_indicator <= 1'b0;
			part_is_otp       <= 1'b0;
			part_rd           <= 1'b0;
			part_wr           <= 1'b0;
			part_ref          <= 1'b0;
			part_addr         <= {AW{1'b0}};
			part_data_space   <= 1'b0;
			part_wdata        <= 8'h00;
			part_lock         <= 1'b0;
			refchip_rd        <= 1'b0;
			refchip_addr      <= 16'h0000;
			opt_lo_reg        <= 8'h00;
			opt_hi_reg        <= 8'h00;
		end else begin
			part_rd    <= 1'b0;
			part_wr    <= 1'b0;
			part_lock  <= 1'b0;
			refchip_rd <= 1'b0;
			case (state_reg)
				S_IDLE: begin
					if (go) begin
						cfg_reg           <= pin_s2_reg;
						part_is_otp       <= pin_s2_reg[4];
						fault_indicator   <= 1'b0;
						success_indicator <= 1'b0;
						busy_reg          <= 1'b1;
						err_reg           <= 1'b0;
						prot_reg          <= 1'b0;
						idx_reg           <= {AW{1'b0}};
						phase_reg         <= pin_s2_reg[5] ? PH_DATA : PH_PROG;
						part_ref          <= pin_s2_reg[1];
						if (pin_s2_reg[1])
							op_reg <= OP_READ;
						else if (pin_s2_reg[2])
							op_reg <= OP_PROG;
						else if (!pin_s2_reg[3] && refchip_rdata == `SPS_BLANK_BYTE)
							op_reg <= OP_BLNK;
						else
							op_reg <= OP_VERI;
						if (!pin_s2_reg[1] && pin_s2_reg[3] && !valid_reg) begin
							err_reg   <= 1'b1;              // no usable reference
							state_reg <= S_DONE;
						end else
							state_reg <= S_REQ;
					end
				end
				S_REQ: begin
					if (part_locked && op_reg != OP_PROG) begin
						prot_reg  <= 1'b1;
						state_reg <= S_DONE;
					end else begin
						part_data_space <= (phase_reg == PH_DATA);
						part_addr       <= (phase_reg == PH_OPTL || phase_reg == PH_OPTH) ? opt_addr : idx_reg;
						case (phase_reg)
							PH_PROG: refchip_addr <= {{(16-AW){1'b0}}, idx_reg};
							PH_OPTL: refchip_addr <= size_reg;
							PH_OPTH: refchip_addr <= size_reg + 16'h0001;
							default: refchip_addr <= size_reg + `SPS_DATA_OFS +
								{{(16-AW){1'b0}}, idx_reg};
						endcase
						refchip_rd <= ~c_ram;
						part_rd    <= 1'b1;
						state_reg  <= S_WAIT;
					end
				end
				S_WAIT: begin
					state_reg <= S_DATA;
				end
				S_DATA: begin
					if (op_reg == OP_READ) begin
						if (mis && valid_reg)
							err_reg <= 1'b1;
						if (phase_reg == PH_OPTL)
							opt_lo_reg <= part_rdata;
						if (phase_reg == PH_OPTH)
							opt_hi_reg <= part_rdata;
					end else if (op_reg == OP_PROG) begin
						part_wdata <= want_byte;
						part_wr    <= 1'b1;
					end else if (mis)
						err_reg <= 1'b1;
					if (idx_reg == phase_last) begin
						idx_reg <= {AW{1'b0}};
						if (nph[2])
							state_reg <= (op_reg == OP_PROG && c_protect) ? S_LOCK : S_DONE;
						else begin
							phase_reg <= nph[1:0];
							state_reg <= S_REQ;
						end
					end else begin
						idx_reg   <= idx_reg + AONE;
						state_reg <= S_REQ;
					end
				end
				S_LOCK: begin
					part_lock <= 1'b1;
					if (!part_lock_cmd_ok)
						err_reg <= 1'b1;
					state_reg <= S_DONE;
				end
				S_DONE: begin
					busy_reg <= 1'b0;
					if (op_reg == OP_READ)
						valid_reg <= ~(prot_reg | err_reg);
					success_indicator <= ~err_reg | prot_reg;
					fault_indicator   <= err_reg | prot_reg;
					state_reg         <= S_IDLE;
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	// board memory capture during a reference read
	always @(posedge hclk) begin
		if (state_reg == S_DATA && op_reg == OP_READ) begin
			if (phase_reg == PH_PROG)
				prog_mem[idx_reg] <= part_rdata;
			if (phase_reg == PH_DATA)
				data_mem[idx_reg[7:0]] <= part_rdata;
		end
	end

	// ************************************************************
	// busy flasher
	// ************************************************************
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flash_cnt_reg <= 24'h000000;
			flash_reg     <= 1'b0;
		end else if (!busy_reg) begin
			flash_cnt_reg <= 24'h000000;
			flash_reg     <= 1'b1;
		end else if (flash_cnt_reg == FLASH_CYC[23:0] - 24'h000001) begin
			flash_cnt_reg <= 24'h000000;
			flash_reg     <= ~flash_reg;
		end else
			flash_cnt_reg <= flash_cnt_reg + 24'h000001;
	end
	// lit solid with all others when the part is protected
	assign busy_indicator = busy_reg ? flash_reg :
		(fault_indicator & success_indicator);

	// ************************************************************
	// ahb-lite slave
	// ************************************************************
	reg        dp_wr_reg;
	reg [11:0] dp_addr_reg;
	wire       ap_ok = hsel & htrans[1] & hready;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_reg    <= 1'b0;
			dp_addr_reg  <= 12'h000;
			hrdata       <= 32'h00000000;
			sw_start_reg <= 1'b0;
			two_opt_reg  <= 1'b0;
			size_reg     <= `SPS_SIZE_RST;
			dsize_reg    <= `SPS_DSIZE_RST;
		end else begin
			sw_start_reg <= 1'b0;
			dp_wr_reg    <= ap_ok & hwrite;
			if (ap_ok)
				dp_addr_reg <= {haddr[`SPS_ADDR_MSB:`SPS_ADDR_LSB], 2'b00};
			if (ap_ok && !hwrite) begin
				case ({haddr[`SPS_ADDR_MSB:`SPS_ADDR_LSB], 2'b00})
					`SPS_CTRL_ADDR: hrdata <= {30'h0, two_opt_reg, 1'b0};
					`SPS_STAT_ADDR: hrdata <= {28'h0, valid_reg, fault_indicator,
						success_indicator, busy_reg};
					`SPS_SIZE_ADDR: hrdata <= {16'h0000, size_reg};
					`SPS_DATA_SIZE_ADDR: hrdata <= {16'h0000, dsize_reg};
					default: hrdata <= 32'h00000000;
				endcase
			end
			if (dp_wr_reg) begin
				case (dp_addr_reg)
					`SPS_CTRL_ADDR: begin
						sw_start_reg <= hwdata[`SPS_CTRL_START];
						two_opt_reg  <= hwdata[`SPS_CTRL_TWO_OPT];
					end
					`SPS_SIZE_ADDR: if (!busy_reg)
						size_reg <= hwdata[15:0];
					`SPS_DATA_SIZE_ADDR: if (!busy_reg)
						dsize_reg <= hwdata[15:0];
					default: ;
				endcase
			end
		end
	end
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
endmodule

// ---- bench/sps_properties.sv ----
// sps_properties.sv: timing checks on part strobes and indicators
// assumes: bound to sps_sequencer, one clock hclk, async reset hresetn
module sps_properties #(
	parameter AW = 14
) (
	// clock and reset
	input wire logic          hclk,
	input wire logic          hresetn,
	// part and chip pins
	input wire logic          part_rd,
	input wire logic          part_wr,
	input wire logic          part_ref,
	input wire logic          part_lock,
	input wire logic [AW-1:0] part_addr,
	input wire logic          part_data_space,
	input wire logic          refchip_rd,
	input wire logic [15:0]   refchip_addr,
	// indicators
	input wire logic          busy_indicator,
	input wire logic          fault_indicator,
	input wire logic          success_indicator
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ************************************************************
	// part access
	// ************************************************************
	property p_wr_target;
		part_wr |-> !part_ref;
	endproperty
	a_wr_target: assert property (p_wr_target) else $error("write aimed at reference");
	property p_lock_target;
		part_lock |-> !part_ref && !part_wr;
	endproperty
	a_lock_target: assert property (p_lock_target) else $error("lock misplaced");
	property p_wr_gap;
		part_wr |=> !part_wr ##1 !part_wr;
	endproperty
	a_wr_gap: assert property (p_wr_gap) else $error("write strobes too close");
	property p_rd_gap;
		part_rd |=> !part_rd [*2];
	endproperty
	a_rd_gap: assert property (p_rd_gap) else $error("read strobes too close");
	property p_rd_addr;
		part_rd |=> $stable(part_addr) && $stable(part_data_space);
	endproperty
	a_rd_addr: assert property (p_rd_addr) else $error("part address moved");
	property p_chip_addr;
		refchip_rd |=> $stable(refchip_addr);
	endproperty
	a_chip_addr: assert property (p_chip_addr) else $error("chip address moved");

	// ************************************************************
	// indicators
	// ************************************************************
	property p_rd_clear;
		part_rd || refchip_rd |-> !success_indicator && !fault_indicator;
	endproperty
	a_rd_clear: assert property (p_rd_clear) else $error("old status during run");
	property p_all_lit;
		success_indicator && fault_indicator |-> busy_indicator;
	endproperty
	a_all_lit: assert property (p_all_lit) else $error("all lit without busy");
	property p_ok_hold;
		$rose(success_indicator) |=> success_indicator [*4];
	endproperty
	a_ok_hold: assert property (p_ok_hold) else $error("success not held");
endmodule

// ---- bench/sps_part_model.sv ----
// sps_part_model.sv: target and reference mcu plus reference memory chip
// assumes: byte buses, data taken two cycles after each read strobe
module sps_part_model (
	// clock
	input wire logic        hclk,
	// part bus
	input wire logic        part_rd,
	input wire logic        part_wr,
	input wire logic        part_ref,
	input wire logic [13:0] part_addr,
	input wire logic        part_data_space,
	input wire logic [7:0]  part_wdata,
	input wire logic        part_lock,
	output logic     [7:0]  part_rdata,
	output logic            part_locked,
	// reference chip
	input wire logic        refchip_rd,
	input wire logic [15:0] refchip_addr,
	output logic     [7:0]  refchip_rdata,
	// bench controls
	input wire logic        ref_locked,
	input wire logic        clr_lock,
	input wire logic        chip_empty
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  tgt [0:32767];
	logic [7:0]  refm [0:32767];
	logic        tgt_lock = 0;
	logic [14:0] idx;
	assign idx = {part_data_space, part_addr};
	assign part_locked = part_ref ? ref_locked : tgt_lock;
	// blank target, patterned reference
	initial begin
		part_rdata = 8'h00;
		refchip_rdata = 8'h55;
		for (int i = 0; i < 32768; i++) begin
			tgt[i] = 8'hFF;
			refm[i] = i[7:0] ^ 8'hA5;
		end
	end
	// answer reads, take writes and lock, released lines toggle
	always @(posedge hclk) begin
		part_rdata <= part_rd ? (part_ref ? refm[idx] : tgt[idx]) : ~part_rdata;
		if (part_wr && !part_ref)
			tgt[idx] <= part_wdata;
		if (part_lock)
			tgt_lock <= 1'b1;
		else if (clr_lock)
			tgt_lock <= 1'b0;
		if (chip_empty)
			refchip_rdata <= 8'hFF;
		else if (refchip_rd)
			refchip_rdata <= refchip_addr[7:0] ^ (refchip_addr[8] ? 8'hC3 : 8'h3C);
		else
			refchip_rdata <= (refchip_rdata == 8'h55) ? 8'hAA : 8'h55;
	end
endmodule

// ---- bench/standalone_prog_sequencer_tb.sv ----
// standalone_prog_sequencer_tb.sv: panel-driven runs of the sequencer
// assumes: sps_sequencer with short flash count, part model on far side
`include "sps_regs.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
	$display("BAD %s exp %0h got %0h", n, e, g); end end
module standalone_prog_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, start_key_n = 1;
	logic [31:0] haddr = 0, hwdata = 0, rd;
	logic [1:0]  htrans = 0, seen = 0, sawbusy;
	logic [6:0]  sw = 0;
	logic        ref_locked = 0, clr_lock = 0, chip_empty = 0;
	wire  [31:0] hrdata;
	wire  [13:0] part_addr;
	wire  [15:0] refchip_addr;
	wire  [7:0]  part_wdata, part_rdata, refchip_rdata;
	wire         hreadyout, hresp, busy_indicator, fault_indicator, success_indicator;
	wire         part_is_otp, part_rd, part_wr, part_ref, part_data_space;
	wire         part_locked, part_lock, refchip_rd;
	int          bad_count = 0, tests_run = 0;
	always #25 hclk = ~hclk;
	// option reads at program size 4 and 5
	always @(posedge hclk)
		if (refchip_rd && refchip_addr[15:1] == 15'h0002)
			seen[refchip_addr[0]] <= 1'b1;
	sps_sequencer #(.FLASH_CYC(4)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.start_key_n(start_key_n), .source_master(sw[5]), .operation_select_switch(sw[4]),
		.ram_ref_jumper(sw[6]), .otp_jumper(sw[3]), .eeprom_jumper(sw[2]),
		.read_protect_jumper(sw[1]), .unlock_jumper(sw[0]), .busy_indicator(busy_indicator),
		.fault_indicator(fault_indicator), .success_indicator(success_indicator),
		.part_is_otp(part_is_otp), .part_rd(part_rd), .part_wr(part_wr),
		.part_ref(part_ref), .part_addr(part_addr), .part_data_space(part_data_space),
		.part_wdata(part_wdata), .part_rdata(part_rdata), .part_locked(part_locked),
		.part_lock_cmd_ok(1'b1), .part_lock(part_lock), .refchip_rd(refchip_rd),
		.refchip_addr(refchip_addr), .refchip_rdata(refchip_rdata));
	sps_part_model P (.hclk(hclk), .part_rd(part_rd), .part_wr(part_wr),
		.part_ref(part_ref), .part_addr(part_addr), .part_data_space(part_data_space),
		.part_wdata(part_wdata), .part_lock(part_lock), .part_rdata(part_rdata),
		.part_locked(part_locked), .refchip_rd(refchip_rd), .refchip_addr(refchip_addr),
		.refchip_rdata(refchip_rdata), .ref_locked(ref_locked), .clr_lock(clr_lock),
		.chip_empty(chip_empty));

	// ************************************************************
	// tasks
	// ************************************************************
	task automatic results;
		if (bad_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// wait for hready, bounded
	task automatic rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) begin
			bad_count++;
			results();
		end
	endtask
	// one single word transfer
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {20'h00000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		rdy();
		rd = hrdata;
	endtask
	// press start and wait for a final status
	task automatic run(input logic ok, input logic flt);
		int n;
		sawbusy = 0;
		start_key_n <= 1'b0;
		repeat (6) @(posedge hclk);
		start_key_n <= 1'b1;
		n = 0;
		while (success_indicator !== 1'b1 && fault_indicator !== 1'b1 && n < 2000) begin
			@(posedge hclk);
			if (!success_indicator && !fault_indicator)
				sawbusy[busy_indicator] = 1'b1;
			n++;
		end
		if (n >= 2000) begin
			bad_count++;
			results();
		end
		repeat (2) @(posedge hclk);
		`CHK("ok_fault", {ok, flt}, {success_indicator, fault_indicator})
		`CHK("busy_end", ok & flt, busy_indicator)
		if (ok && !flt)
			`CHK("flashed", 2'h3, sawbusy)
	endtask

	// ************************************************************
	// sequence
	// ************************************************************
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		bus(0, `SPS_SIZE_ADDR, 0);
		`CHK("size_rst", 32'h00001000, rd)
		bus(0, 12'h010, 0);
		`CHK("unmapped", 32'h00000000, rd)
		bus(1, `SPS_SIZE_ADDR, 32'h00000004);
		bus(1, `SPS_DATA_SIZE_ADDR, 32'h00000002);
		bus(1, `SPS_CTRL_ADDR, 32'h00000000);
		sw <= 7'b1100000;
		run(1, 0);
		bus(0, `SPS_STAT_ADDR, 0);
		`CHK("ref_valid", 1'b1, rd[`SPS_ST_VALID])
		sw <= 7'b1011010;
		run(1, 0);
		`CHK("otp", 1'b1, part_is_otp)
		`CHK("prog3", 8'hA6, P.tgt[3])
		`CHK("data0", 8'hA5, P.tgt[16384])
		`CHK("locked", 1'b1, P.tgt_lock)
		sw <= 7'b1000000;
		run(1, 1);
		clr_lock <= 1'b1;
		run(1, 0);
		clr_lock <= 1'b0;
		P.tgt[2] = 8'h00;
		run(0, 1);
		sw <= 7'b1010000;
		run(1, 0);
		`CHK("eprom", 1'b0, part_is_otp)
		`CHK("reprog2", 8'hA7, P.tgt[2])
		ref_locked <= 1'b1;
		sw <= 7'b1100000;
		run(1, 1);
		ref_locked <= 1'b0;
		bus(1, `SPS_CTRL_ADDR, 32'h00000002);
		sw <= 7'b0011101;
		run(1, 0);
		`CHK("eep_prog", 8'hA5, P.tgt[0])
		`CHK("eep_d1", 8'hC6, P.tgt[16385])
		sw <= 7'b0011001;
		run(1, 0);
		`CHK("chip0", 8'h3C, P.tgt[0])
		`CHK("chip3", 8'h3F, P.tgt[3])
		`CHK("opt_rd", 2'h3, seen)
		`CHK("unlock", 8'hFF, P.tgt[4])
		`CHK("opt_hi", 8'h39, P.tgt[5])
		chip_empty <= 1'b1;
		sw <= 7'b0000000;
		run(0, 1);
		for (int i = 0; i < 32768; i++)
			P.tgt[i] = 8'hFF;
		run(1, 0);
		bus(1, `SPS_CTRL_ADDR, 32'h00000003);
		bus(1, `SPS_SIZE_ADDR, 32'h00000008);
		bus(0, `SPS_SIZE_ADDR, 0);
		`CHK("size_busy", 32'h00000004, rd)
		repeat (60) @(posedge hclk);
		bus(0, `SPS_STAT_ADDR, 0);
		`CHK("sw_start", 4'h2, rd[3:0])
		results();
	end
endmodule
bind sps_sequencer sps_properties #(.AW(AW)) u_props (.hclk(hclk), .hresetn(hresetn),
	.part_rd(part_rd), .part_wr(part_wr), .part_ref(part_ref), .part_lock(part_lock),
	.part_addr(part_addr), .part_data_space(part_data_space), .refchip_rd(refchip_rd),
	.refchip_addr(refchip_addr), .busy_indicator(busy_indicator),
	.fault_indicator(fault_indicator), .success_indicator(success_indicator));
